// >>> fan_tach_lamp_runtime_regs.sv
// Purpose: fan tach counting, two blinking lamps and a scan code holder behind AXI4-Lite
// Assumes: tach inputs are asynchronous pins; one clock, async active-high reset
// Notes:   register at index N sits at byte address 4*N, data in bits 7:0
//
// Functional notes
// - fan B pulse period (start to start) counted, read at 5A
// - count latched at pulse start, held
// - count may be invalid until the second pulse after preload
// - preload registers at 5B and 5C
// - preload write restarts that fan's count
// - lamp A bits 1:0, 00 off, 11 on
// - code 01 blinks 1 Hz, half duty
// - code 10 blinks 2 s, quarter duty
// - lamp B same field at 5E
// - scan code register at 5F, read/write
// - 60 to 7F read zero
//
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module fan_tach_lamp_runtime_regs
	import fan_lamp_pkg::*;
#(
	parameter int unsigned HALF_SEC_CYCLES = BLINK_HALF_CYCLES
) (
	input  wire logic              clk_sys,
	input  wire logic              sys_rst,
	input  wire logic [ADDR_W-1:0] s_axil_awaddr,
	input  wire logic              s_axil_awvalid,
	output logic                   s_axil_awready,
	input  wire logic [31:0]       s_axil_wdata,
	input  wire logic [3:0]        s_axil_wstrb,
	input  wire logic              s_axil_wvalid,
	output logic                   s_axil_wready,
	output logic [1:0]             s_axil_bresp,
	output logic                   s_axil_bvalid,
	input  wire logic              s_axil_bready,
	input  wire logic [ADDR_W-1:0] s_axil_araddr,
	input  wire logic              s_axil_arvalid,
	output logic                   s_axil_arready,
	output logic [31:0]            s_axil_rdata,
	output logic [1:0]             s_axil_rresp,
	output logic                   s_axil_rvalid,
	input  wire logic              s_axil_rready,
	input  wire logic              fanATach,
	input  wire logic              fanBTach,
	output logic [7:0]             fanACount,
	output logic                   lampA,
	output logic                   lampB
);

	////////////////////////////////////////////////////////////////////////////////
	// state

	typedef struct packed {
		logic [9:0]      awIdx;
		logic            awHave;
		logic [7:0]      wData;
		logic            wLane0;
		logic            wHave;
		logic            bValid;
		logic [1:0]      bResp;
		logic            rValid;
		logic [7:0]      rData;
		logic [1:0]      rResp;
		logic [1:0][7:0] preload;
		logic [1:0][7:0] count;
		logic [1:0][7:0] latched;
		logic [1:0]      tachMeta;
		logic [1:0]      tachSync;
		logic [1:0]      tachPrev;
		logic [15:0]     tickCnt;
		logic [31:0]     halfCnt;
		lampPhase_t      phase;
		logic [7:0]      lampACtl;
		logic [7:0]      lampBCtl;
		logic [7:0]      scanCode;
	} regState_t;

	regState_t s_q;
	regState_t s_d;

	logic [1:0] tachIn;
	logic       tick;
	logic       halfTick;
	logic       doWrite;
	logic [9:0] arIdx;

	assign tachIn = {fanBTach, fanATach};
	assign arIdx  = s_axil_araddr[ADDR_W-1:2];

	////////////////////////////////////////////////////////////////////////////////
	// read decode

	function automatic logic [8:0] readReg(input regState_t s, input logic [9:0] idx);
		logic [8:0] r;
		r = {1'b1, 8'h00};
		unique case (idx)
			IDX_FAN_B_SPEED_COUNT:   r = {1'b0, s.latched[1]};
			IDX_FAN_A_COUNT_PRELOAD: r = {1'b0, s.preload[0]};
			IDX_FAN_B_COUNT_PRELOAD: r = {1'b0, s.preload[1]};
			IDX_LAMP_A_CONTROL:      r = {1'b0, s.lampACtl};
			IDX_LAMP_B_CONTROL:      r = {1'b0, s.lampBCtl};
			IDX_SCAN_CODE_HOLD:      r = {1'b0, s.scanCode};
			default: begin
				if (idx >= IDX_RESERVED_FIRST && idx <= IDX_RESERVED_LAST) begin
					r = {1'b0, 8'h00};
				end
			end
		endcase
		return r;
	endfunction : readReg

	////////////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		logic [8:0] rd;
		logic [8:0] wrChk;
		rd       = 9'h000;
		wrChk    = 9'h000;
		s_d      = s_q;
		tick     = (s_q.tickCnt == 16'(TACH_TICK_CYCLES - 1));
		halfTick = (s_q.halfCnt == 32'(HALF_SEC_CYCLES - 1));
		doWrite  = s_q.awHave && s_q.wHave && !s_q.bValid;

		// write address and data, either order
		if (s_axil_awvalid && s_axil_awready) begin
			s_d.awIdx  = s_axil_awaddr[ADDR_W-1:2];
			s_d.awHave = 1'b1;
		end
		if (s_axil_wvalid && s_axil_wready) begin
			s_d.wData  = s_axil_wdata[7:0];
			s_d.wLane0 = s_axil_wstrb[0];
			s_d.wHave  = 1'b1;
		end
		if (s_q.bValid && s_axil_bready) begin
			s_d.bValid = 1'b0;
		end

		// blink timebase
		s_d.halfCnt = halfTick ? 32'h00000000 : s_q.halfCnt + 32'h00000001;
		if (halfTick) begin
			s_d.phase = s_q.phase + 2'h1;
		end

		// tach sampling and counting
		s_d.tickCnt  = tick ? 16'h0000 : s_q.tickCnt + 16'h0001;
		s_d.tachMeta = tachIn;
		s_d.tachSync = s_q.tachMeta;
		s_d.tachPrev = s_q.tachSync;
		for (int f = 0; f < 2; f++) begin
			if (s_q.tachSync[f] && !s_q.tachPrev[f]) begin
				s_d.latched[f] = s_q.count[f];
				s_d.count[f]   = s_q.preload[f];
			end else if (tick) begin
				if (s_q.count[f] != COUNT_MAX) begin
					s_d.count[f] = s_q.count[f] + 8'h01;
				end
			end
		end

		// register writes
		if (doWrite) begin
			s_d.awHave = 1'b0;
			s_d.wHave  = 1'b0;
			s_d.bValid = 1'b1;
			wrChk      = readReg(s_q, s_q.awIdx);
			s_d.bResp  = wrChk[8] ? RESP_SLVERR : RESP_OKAY;
			if (s_q.wLane0) begin
				unique case (s_q.awIdx)
					IDX_FAN_A_COUNT_PRELOAD: begin
						s_d.preload[0] = s_q.wData;
						s_d.count[0]   = s_q.wData;
					end
					IDX_FAN_B_COUNT_PRELOAD: begin
						s_d.preload[1] = s_q.wData;
						s_d.count[1]   = s_q.wData;
					end
					IDX_LAMP_A_CONTROL:      s_d.lampACtl = s_q.wData;
					IDX_LAMP_B_CONTROL:      s_d.lampBCtl = s_q.wData;
					IDX_SCAN_CODE_HOLD:      s_d.scanCode = s_q.wData;
					default:                 s_d.scanCode = s_q.scanCode;
				endcase
			end
		end

		// read channel
		if (s_q.rValid && s_axil_rready) begin
			s_d.rValid = 1'b0;
		end
		if (s_axil_arvalid && s_axil_arready) begin
			rd         = readReg(s_q, arIdx);
			s_d.rValid = 1'b1;
			s_d.rData  = rd[7:0];
			s_d.rResp  = rd[8] ? RESP_SLVERR : RESP_OKAY;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// registers

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// lamps

	lamp_drive_if lampAIf ();
	lamp_drive_if lampBIf ();

	// only bits 1:0 reach the lamp
	assign lampAIf.code  = s_q.lampACtl[LAMP_CODE_LSB +: LAMP_CODE_W];
	assign lampAIf.phase = s_q.phase;
	assign lampBIf.code  = s_q.lampBCtl[LAMP_CODE_LSB +: LAMP_CODE_W];
	assign lampBIf.phase = s_q.phase;

	lamp_driver lampADrv (
		.clk_sys (clk_sys),
		.sys_rst (sys_rst),
		.lamp    (lampAIf.drv)
	);

	lamp_driver lampBDrv (
		.clk_sys (clk_sys),
		.sys_rst (sys_rst),
		.lamp    (lampBIf.drv)
	);

	assign lampA = lampAIf.lampOn;
	assign lampB = lampBIf.lampOn;

	////////////////////////////////////////////////////////////////////////////////
	// outputs

	assign s_axil_awready = !s_q.awHave && !s_q.bValid;
	assign s_axil_wready  = !s_q.wHave && !s_q.bValid;
	assign s_axil_bvalid  = s_q.bValid;
	assign s_axil_bresp   = s_q.bResp;
	assign s_axil_arready = !s_q.rValid;
	assign s_axil_rvalid  = s_q.rValid;
	assign s_axil_rdata   = {24'h000000, s_q.rData};
	assign s_axil_rresp   = s_q.rResp;
	assign fanACount      = s_q.latched[0];

endmodule : fan_tach_lamp_runtime_regs
`default_nettype wire

// >>> fan_lamp_pkg.sv
// Purpose: constants and types for the fan speed, lamp and scan code registers
// Assumes: 100 MHz system clock, AXI4-Lite register access
// Notes:   printed offsets are register indices; byte address is four times the index
package fan_lamp_pkg;

	localparam int unsigned ADDR_W        = 12;
	localparam int unsigned CLK_PERIOD_NS = 10;

	// register indices
	localparam logic [9:0] IDX_FAN_B_SPEED_COUNT   = 10'h05a;
	localparam logic [9:0] IDX_FAN_A_COUNT_PRELOAD = 10'h05b;
	localparam logic [9:0] IDX_FAN_B_COUNT_PRELOAD = 10'h05c;
	localparam logic [9:0] IDX_LAMP_A_CONTROL      = 10'h05d;
	localparam logic [9:0] IDX_LAMP_B_CONTROL      = 10'h05e;
	localparam logic [9:0] IDX_SCAN_CODE_HOLD      = 10'h05f;
	localparam logic [9:0] IDX_RESERVED_FIRST      = 10'h060;
	localparam logic [9:0] IDX_RESERVED_LAST       = 10'h07f;

	// field layout and reset values
	localparam int unsigned LAMP_CODE_LSB = 0;
	localparam int unsigned LAMP_CODE_W   = 2;
	localparam logic [7:0]  REG_RESET     = 8'h00;
	localparam logic [7:0]  COUNT_MAX     = 8'hff;

	// lamp codes
	localparam logic [1:0] LAMP_OFF        = 2'h0;
	localparam logic [1:0] LAMP_BLINK_HALF = 2'h1;
	localparam logic [1:0] LAMP_BLINK_QRTR = 2'h2;
	localparam logic [1:0] LAMP_ON         = 2'h3;

	// timing
	localparam int unsigned TACH_TICK_NS      = 10000;
	localparam int unsigned TACH_TICK_CYCLES  = TACH_TICK_NS / CLK_PERIOD_NS;
	localparam int unsigned BLINK_HALF_MS     = 500;
	localparam int unsigned BLINK_HALF_CYCLES = (BLINK_HALF_MS * 1000000) / CLK_PERIOD_NS;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef logic [1:0] lampPhase_t;

endpackage : fan_lamp_pkg

// >>> lamp_drive_if.sv
// Purpose: carries one lamp's code and blink phase to its driver, and the lamp level back
// Assumes: single clock domain
// Notes:   phase advances every half second
`timescale 1ns/1ps
`default_nettype none
interface lamp_drive_if;
	import fan_lamp_pkg::*;
	logic [1:0] code;
	lampPhase_t phase;
	logic       lampOn;
	modport ctrl (output code, output phase, input lampOn);
	modport drv  (input code, input phase, output lampOn);
endinterface : lamp_drive_if
`default_nettype wire

// >>> lamp_driver.sv
// Purpose: turns a lamp code and the shared blink phase into a lamp level
// Assumes: phase counts 0..3, one step per half second
// Notes:   output is registered
`timescale 1ns/1ps
`default_nettype none
module lamp_driver
	import fan_lamp_pkg::*;
(
	input  wire logic  clk_sys,
	input  wire logic  sys_rst,
	lamp_drive_if.drv  lamp
);

	typedef struct packed {
		logic on;
	} drvState_t;

	drvState_t s_q;
	drvState_t s_d;

	always_comb begin
		s_d = s_q;
		unique case (lamp.code)
			LAMP_OFF:        s_d.on = 1'b0;
			LAMP_BLINK_HALF: s_d.on = ~lamp.phase[0];
			LAMP_BLINK_QRTR: s_d.on = (lamp.phase == 2'h0);
			LAMP_ON:         s_d.on = 1'b1;
		endcase
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign lamp.lampOn = s_q.on;

endmodule : lamp_driver
`default_nettype wire

// >>> fan_tach_model.sv
// Purpose: tach pulse source standing in for both fans
// Assumes: period counted in clk_sys cycles
// Notes:   fan B runs offset from fan A
`timescale 1ns/1ps
`default_nettype none
module fan_tach_model #(
	parameter int PERIOD = 5000
) (
	input  wire logic clk_sys,
	output logic      fanATach = 1'b0,
	output logic      fanBTach = 1'b0
);
	int cnt = 0;
	always @(posedge clk_sys) begin
		cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
		fanATach <= (cnt < 20);
		fanBTach <= (cnt >= 1700 && cnt < 1720);
	end
endmodule : fan_tach_model
`default_nettype wire

// >>> fan_lamp_sva.sv
// Purpose: port checks for the fan, lamp and scan code registers
// Assumes: one clock domain, async active-high reset
// Notes:   master offers write address and data together
`timescale 1ns/1ps
`default_nettype none
module fan_lamp_sva (
	input wire logic        clk_sys,
	input wire logic        sys_rst,
	input wire logic        s_axil_awvalid,
	input wire logic        s_axil_awready,
	input wire logic        s_axil_wvalid,
	input wire logic        s_axil_wready,
	input wire logic [1:0]  s_axil_bresp,
	input wire logic        s_axil_bvalid,
	input wire logic        s_axil_bready,
	input wire logic        s_axil_arvalid,
	input wire logic        s_axil_arready,
	input wire logic [31:0] s_axil_rdata,
	input wire logic        s_axil_rvalid,
	input wire logic        s_axil_rready,
	input wire logic        fanATach,
	input wire logic [7:0]  fanACount
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	sequence wrTaken;
		s_axil_awvalid && s_axil_awready && s_axil_wvalid && s_axil_wready;
	endsequence
	sequence rdTaken;
		s_axil_arvalid && s_axil_arready;
	endsequence
	a_write_answer: assert property (wrTaken |-> ##2 s_axil_bvalid)
		else $error("write not answered");
	a_read_answer: assert property (rdTaken |=> s_axil_rvalid)
		else $error("read not answered");
	a_bresp_hold: assert property (s_axil_bvalid && !s_axil_bready |=>
		s_axil_bvalid && $stable(s_axil_bresp)) else $error("write answer dropped");
	a_rdata_hold: assert property (s_axil_rvalid && !s_axil_rready |=>
		s_axil_rvalid && $stable(s_axil_rdata)) else $error("read answer dropped");
	a_ar_refused: assert property (s_axil_rvalid |-> !s_axil_arready)
		else $error("read taken while busy");
	a_aw_refused: assert property (s_axil_bvalid |-> !s_axil_awready && !s_axil_wready)
		else $error("write taken while busy");
	a_rdata_upper: assert property (s_axil_rvalid |-> s_axil_rdata[31:8] == 24'h0)
		else $error("upper read bits set");
	a_count_latch: assert property ($changed(fanACount) |-> $past(fanATach, 2))
		else $error("count changed without pulse");
endmodule : fan_lamp_sva
`default_nettype wire

// >>> testbench.sv
// Purpose: bench for fan tach, lamp and scan code registers
// Assumes: half second shortened to 8 cycles, tach period 5000 cycles
// Notes:   reads queue expected data for the monitor
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import fan_lamp_pkg::*;
	logic clk_sys = 1'b0;
	logic sys_rst = 1'b1;
	logic [ADDR_W-1:0] s_axil_awaddr = '0, s_axil_araddr = '0;
	logic s_axil_awvalid = 1'b0, s_axil_wvalid = 1'b0, s_axil_bready = 1'b0;
	logic s_axil_arvalid = 1'b0, s_axil_rready = 1'b0;
	logic [31:0] s_axil_wdata = '0, s_axil_rdata;
	logic [3:0] s_axil_wstrb = 4'hf;
	logic s_axil_awready, s_axil_wready, s_axil_bvalid, s_axil_arready, s_axil_rvalid;
	logic [1:0] s_axil_bresp, s_axil_rresp;
	logic fanATach, fanBTach, lampA, lampB;
	logic [7:0] fanACount;
	int failures = 0, check_count = 0, seed = 40670;
	logic [33:0] expQ[$];
	always #5 clk_sys = ~clk_sys;
	fan_tach_lamp_runtime_regs #(.HALF_SEC_CYCLES(8)) fan_tach_lamp_runtime_regs_inst (.*);
	fan_tach_model fan_tach_model_inst (.*);
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			failures++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic print_verdict;
		$display("checks=%0d failures=%0d", check_count, failures);
		if (failures == 0 && check_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : print_verdict
	task automatic step(inout int n);
		@(posedge clk_sys);
		n++;
		if (n > 200) begin
			failures++;
			print_verdict();
		end
	endtask : step
	task automatic wr(input logic [9:0] idx, input logic [7:0] d, input logic [1:0] er = RESP_OKAY);
		int n = 0;
		logic awOpen = 1'b1;
		logic wOpen = 1'b1;
		s_axil_awaddr <= {idx, 2'b00};
		s_axil_wdata <= {24'h0, d};
		s_axil_awvalid <= 1'b1;
		s_axil_wvalid <= 1'b1;
		while (awOpen || wOpen) begin
			step(n);
			if (awOpen && s_axil_awready === 1'b1) begin
				awOpen = 1'b0;
				s_axil_awvalid <= 1'b0;
			end
			if (wOpen && s_axil_wready === 1'b1) begin
				wOpen = 1'b0;
				s_axil_wvalid <= 1'b0;
			end
		end
		do step(n); while (s_axil_bvalid !== 1'b1);
		check(32'(s_axil_bresp), 32'(er));
		s_axil_bready <= 1'b1;
		step(n);
		s_axil_bready <= 1'b0;
	endtask : wr
	task automatic rd(input logic [9:0] idx, input logic [31:0] e, input logic [1:0] er = RESP_OKAY);
		int n = 0;
		expQ.push_back({er, e});
		s_axil_araddr <= {idx, 2'b00};
		s_axil_arvalid <= 1'b1;
		do step(n); while (s_axil_arready !== 1'b1);
		s_axil_arvalid <= 1'b0;
		do step(n); while (s_axil_rvalid !== 1'b1);
		s_axil_rready <= 1'b1;
		step(n);
		s_axil_rready <= 1'b0;
	endtask : rd
	always @(posedge clk_sys) begin
		logic [33:0] note;
		if (s_axil_rvalid === 1'b1 && s_axil_rready === 1'b1 && expQ.size() > 0) begin
			note = expQ.pop_front();
			check(s_axil_rdata, note[31:0]);
			check(32'(s_axil_rresp), 32'(note[33:32]));
		end
	end
	task automatic lampRun(input logic [1:0] c, input int lit);
		int a = 0, b = 0;
		wr(IDX_LAMP_A_CONTROL, {6'($random(seed)), c});
		wr(IDX_LAMP_B_CONTROL, {6'($random(seed)), c});
		repeat (32) begin
			@(posedge clk_sys);
			a += lampA;
			b += lampB;
		end
		check(a, lit);
		check(b, lit);
	endtask : lampRun
	task automatic fanRun(input logic [7:0] pa, input logic [7:0] pb);
		wr(IDX_FAN_A_COUNT_PRELOAD, pa);
		wr(IDX_FAN_B_COUNT_PRELOAD, pb);
		repeat (15100) @(posedge clk_sys);
		rd(IDX_FAN_B_SPEED_COUNT, (pb > 8'hfa) ? 32'hff : {24'h0, pb + 8'd5});
		check(fanACount, (pa > 8'hfa) ? 8'hff : pa + 8'd5);
	endtask : fanRun
	initial begin
		logic [7:0] v[6];
		int lit[4] = '{0, 16, 8, 32};
		repeat (8) @(posedge clk_sys);
		sys_rst <= 1'b0;
		for (int i = 0; i < 6; i++) rd(IDX_FAN_B_SPEED_COUNT + 10'(i), 32'h0);
		for (int i = 0; i < 6; i++) begin
			v[i] = 8'($random(seed));
			wr(IDX_FAN_B_SPEED_COUNT + 10'(i), v[i]);
		end
		v[0] = 8'h00;
		for (int i = 0; i < 6; i++) rd(IDX_FAN_B_SPEED_COUNT + 10'(i), {24'h0, v[i]});
		wr(IDX_RESERVED_FIRST + 10'($random(seed) & 31), 8'hff);
		rd(IDX_RESERVED_FIRST, 32'h0);
		rd(IDX_RESERVED_LAST, 32'h0);
		rd(10'h000, 32'h0, RESP_SLVERR);
		wr(10'h000, 8'hff, RESP_SLVERR);
		s_axil_wstrb <= 4'h0;
		wr(IDX_SCAN_CODE_HOLD, ~v[5]);
		s_axil_wstrb <= 4'hf;
		rd(IDX_SCAN_CODE_HOLD, {24'h0, v[5]});
		for (int i = 0; i < 4; i++) lampRun(2'(i), lit[i]);
		fanRun(8'($random(seed)) & 8'hf0, 8'($random(seed)) & 8'hf0);
		fanRun(8'hfe, 8'hfc);
		print_verdict();
	end
endmodule : testbench
bind fan_tach_lamp_runtime_regs fan_lamp_sva fan_lamp_sva_inst (
	.clk_sys        (clk_sys),
	.sys_rst        (sys_rst),
	.s_axil_awvalid (s_axil_awvalid),
	.s_axil_awready (s_axil_awready),
	.s_axil_wvalid  (s_axil_wvalid),
	.s_axil_wready  (s_axil_wready),
	.s_axil_bresp   (s_axil_bresp),
	.s_axil_bvalid  (s_axil_bvalid),
	.s_axil_bready  (s_axil_bready),
	.s_axil_arvalid (s_axil_arvalid),
	.s_axil_arready (s_axil_arready),
	.s_axil_rdata   (s_axil_rdata),
	.s_axil_rvalid  (s_axil_rvalid),
	.s_axil_rready  (s_axil_rready),
	.fanATach       (fanATach),
	.fanACount      (fanACount)
);
`default_nettype wire
